// ### verilog/cfwe_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - In CAN active state, low transmit input starts the dominant-timeout timer.
// - Transmit low beyond the timeout disables the transmitter; bus returns recessive.
// - Transmit input returning high clears and restarts the timer.
// - Timeout sets CAN failure if enabled, sets timeout status, clears transmitter-active.
// - Mode 01 with failure capture: supply below 90% sets failure and supply-low bit.
// - Wake edges raise wake events per rising and falling enables, both allowed.
// - Wake status bit 1 reads pin level, 1 above threshold, 0 below.
// - Level always valid in Normal; elsewhere only while an edge enable is set.
// - Captured events are stored and, if enabled, signalled on receive output.
// - Sleep needs a regular wake source; CAN and wake-pin edges are regular.
// - CAN wake capture off after power-on; captured only while transceiver offline.
// - Power-on event always captured on leaving Off mode; cannot be disabled.
// - Register port failure outside Sleep: bad clock count, illegal code, locked write.
// - Window watchdog failure resets at once; timeout overflow resets only if pending.
// - Host supply undervoltage captured when enabled, never in Sleep.
// - Bus silence captured after silence timeout on active bus, needs detect enable.
// - CAN failure on undervoltage deactivation or clamped transmit outside Sleep.
// - Overtemperature warning captured when enabled, except in Sleep.
// - Sensor supply over and under events separately enabled, off at power-on.
// - Event flags clear only on writing 1; 0 leaves them; many per write.
// - Offline with host supply on, receive output held low while events pend.
module cfwe_top #(
  parameter int TXD_TIMEOUT_CYCLES = cfwe_pkg::TXD_DOM_TIMEOUT_CYC,
  parameter int SILENCE_CYCLES = cfwe_pkg::BUS_SILENCE_CYC,
  parameter bit HAS_SENSOR_SUPPLY = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic txd_pin,
  input wire logic wake_pin,
  input wire logic can_rx_bus,
  input wire logic v1_low_cmp,
  input wire logic otw_cmp,
  input wire logic vext_over_cmp,
  input wire logic vext_under_cmp,
  input wire logic [1:0] sbc_mode_code,
  input wire logic can_active,
  input wire logic can_offline,
  input wire logic host_supply_on,
  input wire logic bus_wakeup_detect,
  input wire logic selective_frame_error,
  input wire logic sleep_request,
  input wire logic cmd_end,
  input wire logic [5:0] cmd_bit_count,
  input wire logic illegal_code,
  input wire logic locked_write,
  input wire logic wd_window_mode,
  input wire logic wd_window_fail,
  input wire logic wd_timeout_overflow,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic txd_to_trx_q,
  output logic tx_enable_q,
  output logic rxd_q,
  output logic sys_reset_q
);
  if (TXD_TIMEOUT_CYCLES < 1 || SILENCE_CYCLES < 1) begin : g_bad_timeout
    $error("cfwe_top: timeouts must be at least 1");
  end

  // Set wins over a clear landing in the same cycle
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // Pin inputs
  // One synchroniser for all lanes keeps their latency equal
  logic [cfwe_pkg::PIN_COUNT-1:0] pin_q;
  logic [cfwe_pkg::PIN_COUNT-1:0] pin_prev_q;
  cfwe_sync3 #(
    .WIDTH(cfwe_pkg::PIN_COUNT),
    .INIT(cfwe_pkg::RST_PINS)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({vext_under_cmp, vext_over_cmp, otw_cmp, v1_low_cmp, can_rx_bus, wake_pin,
               txd_pin}),
    .level_q(pin_q)
  );
  wire txd_s = pin_q[cfwe_pkg::PIN_TXD];
  wire wake_s = pin_q[cfwe_pkg::PIN_WAKE];
  wire rxbus_s = pin_q[cfwe_pkg::PIN_RXBUS];
  wire v1_low_s = pin_q[cfwe_pkg::PIN_V1LOW];

  // Registers
  logic [1:0] can_mode_control_q;
  logic [7:0] sys_en_q;
  logic [7:0] sup_en_q;
  logic [7:0] trx_en_q;
  logic [7:0] wake_en_q;
  logic [7:0] sys_ev_q;
  logic [7:0] sup_ev_q;
  logic [7:0] trx_ev_q;
  logic [7:0] wake_ev_q;
  logic wake_level_status_q;
  logic txd_timeout_status_q;
  logic trx_supply_low_status_q;
  logic dom_exp_prev_q;
  logic bus_was_active_q;

  wire in_sleep = (sbc_mode_code == cfwe_pkg::MODE_SLEEP);
  wire in_normal = (sbc_mode_code == cfwe_pkg::MODE_NORMAL);
  wire can_failure_capture_en = trx_en_q[cfwe_pkg::BIT_CF];
  wire bus_silence_detect_en = trx_en_q[cfwe_pkg::BIT_CBS];
  wire wake_rise_en = wake_en_q[cfwe_pkg::BIT_WPR];
  wire wake_fall_en = wake_en_q[cfwe_pkg::BIT_WPF];

  // Dominant timeout
  logic dom_expired;
  cfwe_timer #(
    .LIMIT(TXD_TIMEOUT_CYCLES)
  ) u_dom_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(can_active & ~txd_s),
    .expired_q(dom_expired)
  );
  wire dom_event = rise(dom_expired, dom_exp_prev_q) & ~in_sleep;

  // Bus silence
  wire rx_edge = rxbus_s ^ pin_prev_q[cfwe_pkg::PIN_RXBUS];
  logic silence_expired;
  cfwe_timer #(
    .LIMIT(SILENCE_CYCLES)
  ) u_silence_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(bus_was_active_q & bus_silence_detect_en & ~rx_edge),
    .expired_q(silence_expired)
  );

  // Event sources
  wire v1_fall = rise(v1_low_s, pin_prev_q[cfwe_pkg::PIN_V1LOW]) & ~in_sleep;
  wire uv_trx_off = v1_fall & (can_mode_control_q == cfwe_pkg::CMC_ACTIVE_UV);
  wire wake_rise = rise(wake_s, pin_prev_q[cfwe_pkg::PIN_WAKE]);
  wire wake_fall = rise(pin_prev_q[cfwe_pkg::PIN_WAKE], wake_s);
  wire otw_rise = rise(pin_q[cfwe_pkg::PIN_OTW], pin_prev_q[cfwe_pkg::PIN_OTW]);
  wire sensor_supply_over_event_rise = rise(pin_q[cfwe_pkg::PIN_SENSOR_SUPPLY_OVER_EVENT], pin_prev_q[cfwe_pkg::PIN_SENSOR_SUPPLY_OVER_EVENT]);
  wire sensor_supply_under_event_rise = rise(pin_q[cfwe_pkg::PIN_SENSOR_SUPPLY_UNDER_EVENT], pin_prev_q[cfwe_pkg::PIN_SENSOR_SUPPLY_UNDER_EVENT]);
  // Count only judged with cmd_end, mid-command values are meaningless
  wire bad_count = (cmd_bit_count != cfwe_pkg::CNT_16) && (cmd_bit_count != cfwe_pkg::CNT_24)
                   && (cmd_bit_count != cfwe_pkg::CNT_32);
  wire regport_failure_event_hit = ((cmd_end & bad_count) | illegal_code | locked_write) & ~in_sleep;

  wire [7:0] sys_set = (8'h01 << cfwe_pkg::BIT_OTW) & {8{otw_rise & ~in_sleep}}
                     | (8'h01 << cfwe_pkg::BIT_REGPORT_FAILURE_EVENT) & {8{regport_failure_event_hit}}
                     | (8'h01 << cfwe_pkg::BIT_WDF) & {8{wd_window_fail | wd_timeout_overflow}};
  wire [7:0] sup_set = (8'h01 << cfwe_pkg::BIT_V1U) & {8{v1_fall & host_supply_on}}
                     | (8'h01 << cfwe_pkg::BIT_SENSOR_SUPPLY_OVER_EVENT) & {8{sensor_supply_over_event_rise & HAS_SENSOR_SUPPLY}}
                     | (8'h01 << cfwe_pkg::BIT_SENSOR_SUPPLY_UNDER_EVENT) & {8{sensor_supply_under_event_rise & HAS_SENSOR_SUPPLY}};
  wire [7:0] trx_set = (8'h01 << cfwe_pkg::BIT_CW) & {8{bus_wakeup_detect & can_offline}}
                     | (8'h01 << cfwe_pkg::BIT_CF) & {8{dom_event | uv_trx_off}}
                     | (8'h01 << cfwe_pkg::BIT_CBS) & {8{silence_expired}}
                     | (8'h01 << cfwe_pkg::BIT_SELECTIVE_FRAME_ERROR_EVENT) & {8{selective_frame_error}};
  wire [7:0] wake_set = (8'h01 << cfwe_pkg::BIT_WPR) & {8{wake_rise}}
                      | (8'h01 << cfwe_pkg::BIT_WPF) & {8{wake_fall}};

  // Always-captured events bypass the enables
  wire [7:0] sys_mask = sys_en_q | (8'h01 << cfwe_pkg::BIT_WDF);
  wire [7:0] trx_mask = trx_en_q | (8'h01 << cfwe_pkg::BIT_SELECTIVE_FRAME_ERROR_EVENT);
  wire [7:0] sys_cap = sys_set & sys_mask;
  wire [7:0] sup_cap = sup_set & sup_en_q;
  wire [7:0] trx_cap = trx_set & trx_mask;
  wire [7:0] wake_cap = wake_set & wake_en_q;

  // Register writes
  wire wr_sys_ev = reg_wr && (reg_addr == cfwe_pkg::ADDR_SYS_EV);
  wire wr_sup_ev = reg_wr && (reg_addr == cfwe_pkg::ADDR_SUP_EV);
  wire wr_trx_ev = reg_wr && (reg_addr == cfwe_pkg::ADDR_TRX_EV);
  wire wr_wake_ev = reg_wr && (reg_addr == cfwe_pkg::ADDR_WAKE_EV);
  wire [7:0] sys_clr = reg_wdata & {8{wr_sys_ev}};
  wire [7:0] sup_clr = reg_wdata & {8{wr_sup_ev}};
  wire [7:0] trx_clr = reg_wdata & {8{wr_trx_ev}};
  wire [7:0] wake_clr = reg_wdata & {8{wr_wake_ev}};

  wire [3:0] global_ev = {|wake_ev_q, |trx_ev_q, |sup_ev_q, |sys_ev_q};
  wire any_pending = |global_ev;
  wire regular_en = trx_en_q[cfwe_pkg::BIT_CW] | wake_rise_en | wake_fall_en;
  // Timeout overflow only resets when a failure is already pending
  wire wd_reset = (wd_window_fail & wd_window_mode)
                | (wd_timeout_overflow & ~wd_window_mode & sys_ev_q[cfwe_pkg::BIT_WDF]);
  // Refused sleep becomes a reset rather than a dead system
  wire sleep_reset = sleep_request & (~regular_en | any_pending);

  wire wake_level_d = (in_normal | wake_rise_en | wake_fall_en) ? wake_s
                      : wake_level_status_q;

  // Reserved bits and unmapped offsets read as zero
  wire [7:0] rd_mux =
      (reg_addr == cfwe_pkg::ADDR_WAKE_STATUS) ? {6'h00, wake_level_status_q, 1'b0} :
      (reg_addr == cfwe_pkg::ADDR_TRX_STATUS) ?
        {tx_enable_q, 5'h00, trx_supply_low_status_q, txd_timeout_status_q} :
      (reg_addr == cfwe_pkg::ADDR_CAN_CTRL) ? {6'h00, can_mode_control_q} :
      (reg_addr == cfwe_pkg::ADDR_SYS_EN) ? sys_en_q :
      (reg_addr == cfwe_pkg::ADDR_SUP_EN) ? sup_en_q :
      (reg_addr == cfwe_pkg::ADDR_TRX_EN) ? trx_en_q :
      (reg_addr == cfwe_pkg::ADDR_WAKE_EN) ? wake_en_q :
      (reg_addr == cfwe_pkg::ADDR_GLOBAL_EV) ? {4'h0, global_ev} :
      (reg_addr == cfwe_pkg::ADDR_SYS_EV) ? sys_ev_q :
      (reg_addr == cfwe_pkg::ADDR_SUP_EV) ? sup_ev_q :
      (reg_addr == cfwe_pkg::ADDR_TRX_EV) ? trx_ev_q :
      (reg_addr == cfwe_pkg::ADDR_WAKE_EV) ? wake_ev_q : 8'h00;

  wire tx_en_d = can_active & ~dom_expired;
  // Offline signalling only; otherwise the bus receive level passes through
  wire rxd_d = (can_offline & host_supply_on) ? ~any_pending : rxbus_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sys_ev_q <= cfwe_pkg::RST_SYS_EV;
      sup_ev_q <= cfwe_pkg::RST_ZERO;
      trx_ev_q <= cfwe_pkg::RST_ZERO;
      wake_ev_q <= cfwe_pkg::RST_ZERO;
    end else begin
      sys_ev_q <= w1c(sys_ev_q, sys_clr, sys_cap);
      sup_ev_q <= w1c(sup_ev_q, sup_clr, sup_cap);
      trx_ev_q <= w1c(trx_ev_q, trx_clr, trx_cap);
      wake_ev_q <= w1c(wake_ev_q, wake_clr, wake_cap);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      can_mode_control_q <= 2'h0;
      sys_en_q <= cfwe_pkg::RST_ZERO;
      sup_en_q <= cfwe_pkg::RST_ZERO;
      trx_en_q <= cfwe_pkg::RST_ZERO;
      wake_en_q <= cfwe_pkg::RST_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == cfwe_pkg::ADDR_CAN_CTRL) can_mode_control_q <= reg_wdata[1:0];
      if (reg_addr == cfwe_pkg::ADDR_SYS_EN) sys_en_q <= reg_wdata & 8'h06;
      if (reg_addr == cfwe_pkg::ADDR_SUP_EN) sup_en_q <= reg_wdata & 8'h07;
      if (reg_addr == cfwe_pkg::ADDR_TRX_EN) trx_en_q <= reg_wdata & 8'h13;
      if (reg_addr == cfwe_pkg::ADDR_WAKE_EN) wake_en_q <= reg_wdata & 8'h03;
    end
  end

  // Idle pin levels after reset, so no false edge follows it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_prev_q <= cfwe_pkg::RST_PINS;
      dom_exp_prev_q <= 1'b0;
      bus_was_active_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_q;
      dom_exp_prev_q <= dom_expired;
      bus_was_active_q <= rx_edge | (bus_was_active_q & ~silence_expired);
    end
  end

  // Status bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_level_status_q <= 1'b0;
      txd_timeout_status_q <= 1'b0;
      trx_supply_low_status_q <= 1'b0;
    end else begin
      wake_level_status_q <= wake_level_d;
      txd_timeout_status_q <= dom_expired;
      trx_supply_low_status_q <= uv_trx_off | (trx_supply_low_status_q & v1_low_s);
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // Driver forced recessive whenever the transmitter is off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd_to_trx_q <= 1'b1;
      tx_enable_q <= 1'b0;
    end else begin
      txd_to_trx_q <= txd_s | ~tx_en_d;
      tx_enable_q <= tx_en_d;
    end
  end

  // One-cycle reset request per cause; the reset logic stretches it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxd_q <= 1'b1;
      sys_reset_q <= 1'b0;
    end else begin
      rxd_q <= rxd_d;
      sys_reset_q <= wd_reset | sleep_reset;
    end
  end
endmodule

// ### verilog/cfwe_pkg.sv
package cfwe_pkg;

  // Clock
  localparam int CLK_MHZ = 10;

  // Timeout periods in microseconds, cycle counts derived from the clock rate
  localparam int TXD_DOM_TIMEOUT_US = 1000;
  localparam int TXD_DOM_TIMEOUT_CYC = TXD_DOM_TIMEOUT_US * CLK_MHZ;
  localparam int BUS_SILENCE_US = 1000000;
  localparam int BUS_SILENCE_CYC = BUS_SILENCE_US * CLK_MHZ;

  // Register offsets
  localparam logic [6:0] ADDR_CAN_CTRL = 7'h20;
  localparam logic [6:0] ADDR_TRX_STATUS = 7'h22;
  localparam logic [6:0] ADDR_SYS_EN = 7'h04;
  localparam logic [6:0] ADDR_SUP_EN = 7'h1C;
  localparam logic [6:0] ADDR_TRX_EN = 7'h23;
  localparam logic [6:0] ADDR_WAKE_EN = 7'h4C;
  localparam logic [6:0] ADDR_WAKE_STATUS = 7'h4B;
  localparam logic [6:0] ADDR_GLOBAL_EV = 7'h60;
  localparam logic [6:0] ADDR_SYS_EV = 7'h61;
  localparam logic [6:0] ADDR_SUP_EV = 7'h62;
  localparam logic [6:0] ADDR_TRX_EV = 7'h63;
  localparam logic [6:0] ADDR_WAKE_EV = 7'h64;

  // Field positions
  localparam int BIT_PO = 4;
  localparam int BIT_OTW = 2;
  localparam int BIT_REGPORT_FAILURE_EVENT = 1;
  localparam int BIT_WDF = 0;
  localparam int BIT_SENSOR_SUPPLY_OVER_EVENT = 2;
  localparam int BIT_SENSOR_SUPPLY_UNDER_EVENT = 1;
  localparam int BIT_V1U = 0;
  localparam int BIT_SELECTIVE_FRAME_ERROR_EVENT = 5;
  localparam int BIT_CBS = 4;
  localparam int BIT_CF = 1;
  localparam int BIT_CW = 0;
  localparam int BIT_WPR = 1;
  localparam int BIT_WPF = 0;
  localparam int BIT_WAKE_LEVEL_STATUS = 1;
  localparam int BIT_CFS = 0;
  localparam int BIT_VCS = 1;
  localparam int BIT_CTS = 7;

  // Reset values
  localparam logic [7:0] RST_SYS_EV = 8'h10;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [6:0] RST_PINS = 7'h05;

  // Codes
  localparam logic [1:0] CMC_ACTIVE_UV = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [5:0] CNT_16 = 6'h10;
  localparam logic [5:0] CNT_24 = 6'h18;
  localparam logic [5:0] CNT_32 = 6'h20;

  // Synchronised pin lanes
  localparam int PIN_TXD = 0;
  localparam int PIN_WAKE = 1;
  localparam int PIN_RXBUS = 2;
  localparam int PIN_V1LOW = 3;
  localparam int PIN_OTW = 4;
  localparam int PIN_SENSOR_SUPPLY_OVER_EVENT = 5;
  localparam int PIN_SENSOR_SUPPLY_UNDER_EVENT = 6;
  localparam int PIN_COUNT = 7;

endpackage

// ### verilog/cfwe_sync3.sv
`timescale 1ns/1ps
module cfwe_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire [WIDTH-1:0] level_d = (agree & s3_q) | (~agree & level_q);

  if (WIDTH < 1) begin : g_bad_width
    $error("cfwe_sync3: WIDTH must be at least 1");
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
endmodule

// ### verilog/cfwe_timer.sv
`timescale 1ns/1ps
module cfwe_timer #(
  parameter int LIMIT = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  output logic expired_q
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] cnt_q;
  wire at_last = (cnt_q == LAST);

  if (LIMIT < 1) begin : g_bad_limit
    $error("cfwe_timer: LIMIT must be at least 1");
  end

  // Cleared whenever run drops, so every run restarts from zero
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      cnt_q <= '0;
      expired_q <= 1'b0;
    end else if (!expired_q) begin
      cnt_q <= cnt_q + W'(1);
      expired_q <= at_last;
    end
  end
endmodule

// ### sim/cfwe_assertions.sv
`timescale 1ns/1ps
module cfwe_assertions #(
  parameter int TXD_TIMEOUT_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic txd_pin,
  input wire logic wake_pin,
  input wire logic v1_low_cmp,
  input wire logic [1:0] sbc_mode_code,
  input wire logic can_active,
  input wire logic can_offline,
  input wire logic host_supply_on,
  input wire logic selective_frame_error,
  input wire logic wd_window_mode,
  input wire logic wd_window_fail,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_rdata_q,
  input wire logic txd_to_trx_q,
  input wire logic tx_enable_q,
  input wire logic rxd_q,
  input wire logic sys_reset_q
);
  logic [15:0] lo_q;
  logic [3:0] hi_q;
  logic [3:0] wk_q;
  // Raw pin counts; the input sync adds 4-5 cycles, hence the margins
  always_ff @(posedge ref_clk) begin
    if (rst || txd_pin || !can_active) lo_q <= 16'h0000;
    else if (lo_q != 16'hFFFF) lo_q <= lo_q + 16'h0001;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !txd_pin || !can_active || v1_low_cmp || sbc_mode_code != 2'h0) hi_q <= 4'h0;
    else if (hi_q != 4'hF) hi_q <= hi_q + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || $changed(wake_pin)) wk_q <= 4'h0;
    else if (wk_q != 4'hF) wk_q <= wk_q + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  tx_off_a: assert property (!tx_enable_q |-> txd_to_trx_q)
    else $error("driver not recessive while disabled");
  tout_min_a: assert property ($fell(tx_enable_q) && lo_q != 0 |-> lo_q >= TXD_TIMEOUT_CYCLES)
    else $error("dominant timeout too early");
  tout_max_a: assert property (lo_q > TXD_TIMEOUT_CYCLES + 12 |-> !tx_enable_q)
    else $error("dominant timeout missed");
  tx_back_a: assert property (hi_q > 4'h8 |-> tx_enable_q)
    else $error("transmitter not restored");
  tx_pass_a: assert property (tx_enable_q && lo_q > 6 |-> !txd_to_trx_q)
    else $error("dominant not passed to driver");
  wake_read_a: assert property (reg_rd && reg_addr == 7'h4B && wk_q > 4'h7 && sbc_mode_code == 2'h0
    |=> reg_rdata_q == {6'h00, $past(wake_pin), 1'b0})
    else $error("wake level read wrong");
  win_reset_a: assert property (wd_window_mode && wd_window_fail |=> sys_reset_q)
    else $error("window failure gave no reset");
  event_rxd_a: assert property (can_offline && host_supply_on && selective_frame_error
    |-> ##[1:6] !rxd_q)
    else $error("pending event not shown on receive output");
  cover property ($fell(tx_enable_q));
  cover property (sys_reset_q);
  cover property (can_offline && !rxd_q);
endmodule

bind cfwe_top cfwe_assertions #(.TXD_TIMEOUT_CYCLES(TXD_TIMEOUT_CYCLES)) cfwe_assertions_inst (
  .ref_clk, .rst, .txd_pin, .wake_pin, .v1_low_cmp, .sbc_mode_code, .can_active,
  .can_offline, .host_supply_on, .selective_frame_error, .wd_window_mode,
  .wd_window_fail, .reg_rd, .reg_addr, .reg_rdata_q, .txd_to_trx_q, .tx_enable_q,
  .rxd_q, .sys_reset_q);

// ### sim/cfwe_host_model.sv
`timescale 1ns/1ps
module cfwe_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata_q,
  output logic txd_pin,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    txd_pin = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Flags clear on ones only, so callers pass just the bits to clear
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask
  task automatic send_bit(input logic v);
    @(negedge ref_clk);
    txd_pin = v;
  endtask
endmodule

// ### sim/cfwe_top_tb.sv
`timescale 1ns/1ps
module cfwe_top_tb;
  logic ref_clk = 1'b0;
  logic rst, txd_pin, wake_pin, can_rx_bus, v1_low_cmp, otw_cmp, vext_over_cmp;
  logic vext_under_cmp, can_active, can_offline, host_supply_on, bus_wakeup_detect;
  logic selective_frame_error, sleep_request, cmd_end, illegal_code, locked_write;
  logic wd_window_mode, wd_window_fail, wd_timeout_overflow, reg_wr, reg_rd;
  logic txd_to_trx_q, tx_enable_q, rxd_q, sys_reset_q;
  logic [1:0] sbc_mode_code;
  logic [5:0] cmd_bit_count;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q;
  int err_count = 0;
  int check_count = 0;
  int rst_seen = 0;
  cfwe_top #(.TXD_TIMEOUT_CYCLES(20), .SILENCE_CYCLES(50)) cfwe_top_inst (.*);
  cfwe_host_model cfwe_host_model_inst (.*);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sys_reset_q === 1'b1) rst_seen++;
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic [7:0] d;
    cfwe_host_model_inst.rd(a, d);
    chk($sformatf("reg %h", a), e, d & m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic t_reset;
    rchk(7'h61, 8'h10);
    rchk(7'h60, 8'h01);
    rchk(7'h23, 8'h00);
    rchk(7'h1C, 8'h00);
    rchk(7'h04, 8'h00);
    cfwe_host_model_inst.wr(7'h61, 8'h10);
  endtask
  task automatic t_wake;
    logic [7:0] en;
    for (int i = 1; i < 4; i++) begin
      en = 8'(i);
      cfwe_host_model_inst.wr(7'h4C, en);
      wake_pin = 1'b1;
      idle(8);
      rchk(7'h4B, 8'h02);
      wake_pin = 1'b0;
      idle(8);
      rchk(7'h4B, 8'h00);
      rchk(7'h64, en);
      rchk(7'h60, 8'h08);
      cfwe_host_model_inst.wr(7'h64, 8'h00);
      rchk(7'h64, en);
      cfwe_host_model_inst.wr(7'h64, 8'h03);
      rchk(7'h64, 8'h00);
    end
    cfwe_host_model_inst.wr(7'h4B, 8'hFF);
    rchk(7'h4B, 8'h00);
  endtask
  task automatic t_dom;
    cfwe_host_model_inst.wr(7'h23, 8'h02);
    for (int i = 0; i < 2; i++) begin
      cfwe_host_model_inst.send_bit(1'b0);
      idle(15);
      cfwe_host_model_inst.send_bit(1'b1);
      idle(1);
    end
    idle(8);
    rchk(7'h22, 8'h80);
    rchk(7'h63, 8'h00);
    cfwe_host_model_inst.send_bit(1'b0);
    idle(40);
    rchk(7'h22, 8'h01);
    rchk(7'h63, 8'h02);
    chk("tx enable", 8'h00, {7'h00, tx_enable_q});
    chk("tx driver", 8'h01, {7'h00, txd_to_trx_q});
    cfwe_host_model_inst.send_bit(1'b1);
    idle(8);
    rchk(7'h22, 8'h80);
    cfwe_host_model_inst.wr(7'h63, 8'h02);
    rchk(7'h63, 8'h00);
  endtask
  task automatic t_uv;
    cfwe_host_model_inst.wr(7'h20, 8'h01);
    cfwe_host_model_inst.wr(7'h1C, 8'h01);
    v1_low_cmp = 1'b1;
    idle(8);
    rchk(7'h22, 8'h02, 8'h03);
    rchk(7'h63, 8'h02);
    rchk(7'h62, 8'h01);
    v1_low_cmp = 1'b0;
    idle(8);
    cfwe_host_model_inst.wr(7'h62, 8'h01);
    sbc_mode_code = 2'h2;
    v1_low_cmp = 1'b1;
    idle(8);
    rchk(7'h62, 8'h00);
    v1_low_cmp = 1'b0;
    sbc_mode_code = 2'h0;
    idle(8);
  endtask
  task automatic t_wdog;
    int n;
    n = rst_seen;
    wd_window_mode = 1'b1;
    pulse(wd_window_fail);
    idle(3);
    chk("window reset", 8'(n + 1), 8'(rst_seen));
    wd_window_mode = 1'b0;
    cfwe_host_model_inst.wr(7'h61, 8'h01);
    pulse(wd_timeout_overflow);
    idle(3);
    chk("first overflow", 8'(n + 1), 8'(rst_seen));
    rchk(7'h61, 8'h01, 8'h01);
    pulse(wd_timeout_overflow);
    idle(3);
    chk("second overflow", 8'(n + 2), 8'(rst_seen));
    cfwe_host_model_inst.wr(7'h61, 8'h01);
  endtask
  task automatic t_port;
    cfwe_host_model_inst.wr(7'h04, 8'h06);
    for (int i = 0; i < 4; i++) begin
      cmd_bit_count = 6'(8 * i + 16);
      pulse(cmd_end);
      idle(2);
      rchk(7'h61, {6'h00, i == 3, 1'b0}, 8'h02);
    end
    cfwe_host_model_inst.wr(7'h61, 8'h02);
    pulse(illegal_code);
    idle(2);
    rchk(7'h61, 8'h02, 8'h02);
    cfwe_host_model_inst.wr(7'h61, 8'h02);
    sbc_mode_code = 2'h2;
    pulse(locked_write);
    idle(2);
    sbc_mode_code = 2'h0;
    rchk(7'h61, 8'h00, 8'h02);
    pulse(locked_write);
    idle(2);
    rchk(7'h61, 8'h02, 8'h02);
    otw_cmp = 1'b1;
    idle(8);
    otw_cmp = 1'b0;
    rchk(7'h61, 8'h04, 8'h04);
    cfwe_host_model_inst.wr(7'h61, 8'hFF);
  endtask
  task automatic t_sleep;
    int n;
    for (int a = 8'h61; a < 8'h65; a++) cfwe_host_model_inst.wr(7'(a), 8'hFF);
    n = rst_seen;
    pulse(sleep_request);
    idle(3);
    chk("sleep allowed", 8'(n), 8'(rst_seen));
    cfwe_host_model_inst.wr(7'h4C, 8'h00);
    pulse(sleep_request);
    idle(3);
    chk("no wake source", 8'(n + 1), 8'(rst_seen));
    cfwe_host_model_inst.wr(7'h4C, 8'h03);
    pulse(selective_frame_error);
    pulse(sleep_request);
    idle(3);
    chk("event pending", 8'(n + 2), 8'(rst_seen));
    cfwe_host_model_inst.wr(7'h63, 8'hFF);
  endtask
  task automatic t_vext;
    cfwe_host_model_inst.wr(7'h1C, 8'h04);
    vext_over_cmp = 1'b1;
    vext_under_cmp = 1'b1;
    idle(8);
    vext_over_cmp = 1'b0;
    vext_under_cmp = 1'b0;
    rchk(7'h62, 8'h04);
    cfwe_host_model_inst.wr(7'h62, 8'h04);
  endtask
  task automatic t_silence;
    cfwe_host_model_inst.wr(7'h23, 8'h10);
    can_rx_bus = 1'b0;
    idle(20);
    chk("rxd bus", 8'h00, {7'h00, rxd_q});
    rchk(7'h63, 8'h00);
    idle(50);
    rchk(7'h63, 8'h10);
    can_rx_bus = 1'b1;
    cfwe_host_model_inst.wr(7'h63, 8'h10);
  endtask
  task automatic t_offline;
    cfwe_host_model_inst.wr(7'h23, 8'h01);
    pulse(bus_wakeup_detect);
    idle(3);
    rchk(7'h63, 8'h00);
    can_active = 1'b0;
    can_offline = 1'b1;
    idle(4);
    chk("rxd idle", 8'h01, {7'h00, rxd_q});
    pulse(bus_wakeup_detect);
    idle(4);
    rchk(7'h63, 8'h01);
    chk("rxd event", 8'h00, {7'h00, rxd_q});
    cfwe_host_model_inst.wr(7'h63, 8'h01);
    idle(4);
    chk("rxd cleared", 8'h01, {7'h00, rxd_q});
    pulse(selective_frame_error);
    idle(4);
    chk("rxd frame error", 8'h00, {7'h00, rxd_q});
    host_supply_on = 1'b0;
    idle(4);
    chk("rxd no supply", 8'h01, {7'h00, rxd_q});
    host_supply_on = 1'b1;
    cfwe_host_model_inst.wr(7'h63, 8'hFF);
    can_offline = 1'b0;
    can_active = 1'b1;
  endtask
  initial begin
    {rst, can_active, host_supply_on, can_rx_bus} = 4'hF;
    {wake_pin, v1_low_cmp, otw_cmp, vext_over_cmp, vext_under_cmp} = 5'h00;
    {can_offline, bus_wakeup_detect, selective_frame_error, sleep_request} = 4'h0;
    {cmd_end, illegal_code, locked_write} = 3'h0;
    {wd_window_mode, wd_window_fail, wd_timeout_overflow} = 3'h0;
    sbc_mode_code = 2'h0;
    cmd_bit_count = 6'h10;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_wake;
    t_dom;
    t_uv;
    t_wdog;
    t_port;
    t_sleep;
    t_vext;
    t_silence;
    t_offline;
    results;
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    $display("Error watchdog expected finish seen hang");
    results;
  end
endmodule
